//--- core/srm_pkg.sv
// package: constants and types of the stop ramp monitor
package srm_pkg;
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_LAT    = 4'h1;
    localparam logic [3:0] OFS_MARGIN = 4'h2;
    localparam logic [3:0] OFS_ACCEL  = 4'h3;
    localparam logic [3:0] OFS_JERK   = 4'h4;
    localparam logic [3:0] OFS_STAT   = 4'h5;
    localparam logic [3:0] OFS_IRQ    = 4'h6;
    localparam logic [3:0] OFS_MASK   = 4'h7;
    localparam logic [3:0] OFS_SPEED  = 4'h8;
    localparam logic [3:0] OFS_LIMIT  = 4'h9;
    localparam int CTRL_CAT2_BIT  = 0;
    localparam int CTRL_SCURV_BIT = 1;
    localparam int EV_VIOL  = 0;
    localparam int EV_EXPIR = 1;
    localparam int EV_REST  = 2;
    localparam int EV_W     = 3;
    localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RST_LAT    = 32'h0000_0000;
    localparam logic [31:0] RST_MARGIN = 32'h0000_0000;
    localparam logic [31:0] RST_ACCEL  = 32'h0000_0001;
    localparam logic [31:0] RST_JERK   = 32'h0000_0001;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LAT,
        ST_RAMP,
        ST_END
    } srm_state_t;
    typedef struct packed {
        logic        cat2;
        logic        scurve;
        logic [31:0] lat;
        logic [31:0] margin;
        logic [31:0] accel;
        logic [31:0] jerk;
    } srm_cfg_t;
    typedef struct packed {
        logic        out;
        logic        viol;
        logic        expired;
        logic        standstill_en;
        logic [1:0]  state;
    } srm_stat_t;
endpackage : srm_pkg

//--- core/srm_top.sv
// stop ramp monitor with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module srm_top
    import srm_pkg::*;
#(
    parameter int PW = 32,
    parameter int SW = 24
) (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic [5:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic [PW-1:0] pos_in,
    input  wire logic          pos_valid,
    input  wire logic          stop_req,
    input  wire logic          alarm_reset,
    input  wire logic          front_key,
    output logic               stop_ramp_monitor_ok,
    output logic               standstill_monitor_en,
    output logic               irq
);
    generate
        if (SW < 4 || SW > 31 || PW < SW) begin : g_chk
            $error("srm_top: SW must be 4..31 and PW >= SW");
        end
    endgenerate

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    srm_cfg_t    cfg_r;
    srm_state_t  state_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [PW-1:0] pos_prev_r;
    logic        pos_seen_r;
    logic [SW-1:0] speed_r;
    logic [SW-1:0] v0_r;
    logic [31:0] tick_r;
    logic [SW:0] dec_r;
    logic [SW:0] rate_r;
    logic        viol_r;
    logic        expired_r;
    logic        rest_r;
    logic        ss_en_r;
    logic [EV_W-1:0] irq_stat_r;
    logic [EV_W-1:0] irq_mask_r;
    logic        stop_d_r;
    logic [3:0]  reg_idx;
    logic        wr_go;
    logic        rd_go;
    logic [PW-1:0] pos_diff;
    logic [SW:0] limit;
    logic [SW+1:0] lim_wide;
    logic        start;
    logic        ramp_tick;
    logic        over;
    logic        ack_in;
    logic [EV_W-1:0] ev;
    logic [SW:0] acc_cap;
    logic [SW:0] rate_step;

    // bus slave: one wait cycle, answer on the second edge
    assign reg_idx = avs_address[5:2];
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata = rdata_r;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // writes land at the answer edge, the one where waitrequest is low
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_r.cat2   <= RST_CTRL[CTRL_CAT2_BIT];
            cfg_r.scurve <= RST_CTRL[CTRL_SCURV_BIT];
            cfg_r.lat    <= RST_LAT;
            cfg_r.margin <= RST_MARGIN;
            cfg_r.accel  <= RST_ACCEL;
            cfg_r.jerk   <= RST_JERK;
        end else if (wr_go) begin
            unique case (reg_idx)
                OFS_CTRL: begin
                    if (avs_byteenable[0]) begin
                        cfg_r.cat2   <= avs_writedata[CTRL_CAT2_BIT];
                        cfg_r.scurve <= avs_writedata[CTRL_SCURV_BIT];
                    end
                end
                OFS_LAT:    cfg_r.lat    <= be_merge(cfg_r.lat, avs_writedata, avs_byteenable);
                OFS_MARGIN: cfg_r.margin <= be_merge(cfg_r.margin, avs_writedata, avs_byteenable);
                OFS_ACCEL:  cfg_r.accel  <= be_merge(cfg_r.accel, avs_writedata, avs_byteenable);
                OFS_JERK:   cfg_r.jerk   <= be_merge(cfg_r.jerk, avs_writedata, avs_byteenable);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_r <= RD_UNMAPPED;
        end else if (rd_go) begin
            unique case (reg_idx)
                OFS_CTRL:   rdata_r <= {30'h0, cfg_r.scurve, cfg_r.cat2};
                OFS_LAT:    rdata_r <= cfg_r.lat;
                OFS_MARGIN: rdata_r <= cfg_r.margin;
                OFS_ACCEL:  rdata_r <= cfg_r.accel;
                OFS_JERK:   rdata_r <= cfg_r.jerk;
                OFS_STAT:   rdata_r <= {26'h0, stop_ramp_monitor_ok, viol_r, expired_r,
                                        ss_en_r, state_r};
                OFS_IRQ:    rdata_r <= {{(32-EV_W){1'b0}}, irq_stat_r};
                OFS_MASK:   rdata_r <= {{(32-EV_W){1'b0}}, irq_mask_r};
                OFS_SPEED:  rdata_r <= {{(32-SW){1'b0}}, speed_r};
                OFS_LIMIT:  rdata_r <= {{(31-SW){1'b0}}, limit};
                default:    rdata_r <= RD_UNMAPPED;
            endcase
        end
    end

    // speed as absolute position change per encoder sample
    assign pos_diff = pos_in - pos_prev_r;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pos_prev_r <= '0;
            pos_seen_r <= 1'b0;
            speed_r    <= '0;
        end else if (pos_valid) begin
            pos_prev_r <= pos_in;
            pos_seen_r <= 1'b1;
            if (pos_seen_r) begin
                speed_r <= pos_diff[PW-1] ? SW'(-pos_diff) : SW'(pos_diff);
            end
        end
    end

    // activation on rising stop request
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stop_d_r <= 1'b0;
        end else begin
            stop_d_r <= stop_req;
        end
    end

    assign start = stop_req & ~stop_d_r;
    assign ramp_tick = pos_valid & (state_r == ST_RAMP);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            tick_r  <= '0;
        end else if (!stop_req) begin
            state_r <= ST_IDLE;
            tick_r  <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_LAT;
                        tick_r  <= '0;
                    end
                end
                ST_LAT: begin
                    // time counted in encoder samples; equal time ends latency
                    if (pos_valid) begin
                        if (tick_r >= cfg_r.lat) begin
                            state_r <= ST_RAMP;
                        end else begin
                            tick_r <= tick_r + 32'h1;
                        end
                    end
                end
                ST_RAMP: begin
                    if (expired_r) begin
                        state_r <= ST_END;
                    end
                end
                ST_END: begin
                end
            endcase
        end
    end

    // captured speed is the curve start
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            v0_r <= '0;
        end else if (start) begin
            v0_r <= speed_r;
        end
    end

    // deceleration grows by accel (linear) or by a jerk-limited rate (s-curve)
    assign acc_cap = cfg_r.accel[SW:0];
    // compare one bit wider so a large jerk cannot wrap below the cap
    assign rate_step = ({1'b0, rate_r} + {1'b0, cfg_r.jerk[SW:0]} >= {1'b0, acc_cap}) ? acc_cap
                                                                                     : rate_r + cfg_r.jerk[SW:0];

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dec_r  <= '0;
            rate_r <= '0;
        end else if (state_r == ST_IDLE || state_r == ST_LAT) begin
            dec_r  <= '0;
            rate_r <= '0;
        end else if (ramp_tick && !expired_r) begin
            if (cfg_r.scurve) begin
                rate_r <= rate_step;
                dec_r  <= dec_r + rate_step;
            end else begin
                dec_r <= dec_r + acc_cap;
            end
        end
    end

    // limit = captured speed minus deceleration, plus margin
    assign lim_wide = (dec_r >= {1'b0, v0_r}) ? (SW+2)'(cfg_r.margin[SW:0])
                      : (SW+2)'({1'b0, v0_r} - dec_r) + (SW+2)'(cfg_r.margin[SW:0]);
    assign limit = lim_wide[SW+1] ? {(SW+1){1'b1}} : lim_wide[SW:0];
    // equality is within limits
    assign over = (state_r == ST_RAMP || state_r == ST_END) && ({1'b0, speed_r} > limit);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            expired_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            expired_r <= 1'b0;
        end else if (state_r == ST_RAMP && dec_r >= {1'b0, v0_r}) begin
            expired_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rest_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            rest_r <= 1'b0;
        end else if (expired_r && speed_r == '0) begin
            rest_r <= 1'b1;
        end
    end

    // standstill handover only in category 2
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ss_en_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            ss_en_r <= 1'b0;
        end else if (expired_r && cfg_r.cat2) begin
            ss_en_r <= 1'b1;
        end
    end

    // latched violation, set wins over the acknowledge
    assign ack_in = alarm_reset | front_key;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            viol_r <= 1'b0;
        end else if (over) begin
            viol_r <= 1'b1;
        end else if (ack_in) begin
            viol_r <= 1'b0;
        end
    end

    // output: high idle and in latency unless a violation is latched, low on violation or cat1 rest
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stop_ramp_monitor_ok <= 1'b1;
        end else if (over || viol_r) begin
            stop_ramp_monitor_ok <= 1'b0;
        end else if (!cfg_r.cat2 && rest_r) begin
            stop_ramp_monitor_ok <= 1'b0;
        end else begin
            stop_ramp_monitor_ok <= 1'b1;
        end
    end

    assign standstill_monitor_en = ss_en_r;

    // events: edges of violation, curve expiry and rest
    assign ev[EV_VIOL]  = over & ~viol_r;
    assign ev[EV_EXPIR] = (state_r == ST_RAMP) & (dec_r >= {1'b0, v0_r}) & ~expired_r;
    assign ev[EV_REST]  = expired_r & (speed_r == '0) & ~rest_r;

    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_irq
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    irq_stat_r[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    irq_stat_r[gi] <= 1'b1;
                end else if (wr_go && reg_idx == OFS_IRQ && avs_byteenable[0] && avs_writedata[gi]) begin
                    irq_stat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_mask_r <= '0;
        end else if (wr_go && reg_idx == OFS_MASK && avs_byteenable[0]) begin
            irq_mask_r <= avs_writedata[EV_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);
endmodule : srm_top
`default_nettype wire

//--- dv/srm_enc_model.sv
// encoder model: position samples at a set speed, optional deceleration
`timescale 1ns/1ps
`default_nettype none
module srm_enc_model #(
    parameter int TICK = 4
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [31:0] v_set,
    input  wire logic        v_load,
    input  wire logic [31:0] v_dec,
    output logic [31:0]      pos_in,
    output logic             pos_valid
);
    logic [31:0] v_r;
    logic [31:0] p_r;
    logic [3:0]  cnt_r;
    // position is not held between samples
    assign pos_in = pos_valid ? p_r : ~p_r;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt_r <= 4'h0;
            p_r <= 32'h0;
            v_r <= 32'h0;
            pos_valid <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 4'(TICK - 1)) ? 4'h0 : cnt_r + 4'h1;
            pos_valid <= (cnt_r == 4'h0);
            if (cnt_r == 4'h0) begin
                p_r <= p_r + v_r;
            end
            if (v_load) begin
                v_r <= v_set;
            end else if (cnt_r == 4'h0) begin
                v_r <= (v_r > v_dec) ? v_r - v_dec : 32'h0;
            end
        end
    end
endmodule : srm_enc_model
`default_nettype wire

//--- dv/srm_top_props.sv
// assertion checker on the stop ramp monitor ports
`timescale 1ns/1ps
`default_nettype none
module srm_top_props
    import srm_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        stop_req,
    input wire logic        alarm_reset,
    input wire logic        front_key,
    input wire logic        stop_ramp_monitor_ok,
    input wire logic        standstill_monitor_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence bus_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // clear only counts once the monitor has been idle for a cycle
    sequence idle_clear;
        !stop_req && !$past(stop_req) && (alarm_reset || front_key);
    endsequence
    wait_one_a: assert property (bus_take |=> !avs_waitrequest)
        else $error("waitrequest still high after take");
    no_req_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without read");
    latch_hold_a: assert property (
        !stop_ramp_monitor_ok && stop_req && !alarm_reset && !front_key |=> !stop_ramp_monitor_ok)
        else $error("violation released without reset");
    clear_ok_a: assert property (idle_clear |-> ##[1:2] stop_ramp_monitor_ok)
        else $error("reset did not clear violation");
    lat_high_a: assert property (
        $rose(stop_req) && stop_ramp_monitor_ok |=> stop_ramp_monitor_ok [*2])
        else $error("output dropped inside latency");
    fall_cause_a: assert property ($fell(stop_ramp_monitor_ok) |-> $past(stop_req, 2))
        else $error("output dropped while idle");
    stand_off_a: assert property (!stop_req ##1 !stop_req |=> !standstill_monitor_en)
        else $error("standstill enable while idle");
endmodule : srm_top_props
bind srm_top srm_top_props props_u (
    .core_clk(core_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_req(stop_req),
    .alarm_reset(alarm_reset), .front_key(front_key),
    .stop_ramp_monitor_ok(stop_ramp_monitor_ok), .standstill_monitor_en(standstill_monitor_en)
);
`default_nettype wire

//--- dv/tb_top.sv
// testbench for the stop ramp monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import srm_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] pos_in;
    logic        pos_valid;
    logic        stop_req = 1'b0;
    logic        alarm_reset = 1'b0;
    logic        front_key = 1'b0;
    logic        ok;
    logic        sten;
    logic        irq;
    logic [31:0] v_set = 32'h0;
    logic        v_load = 1'b0;
    logic [31:0] v_dec = 32'h0;
    logic [31:0] rd;
    logic [31:0] rst_tab [5] = '{RST_CTRL, RST_LAT, RST_MARGIN, RST_ACCEL, RST_JERK};
    int          bad_count = 0;
    int          cmp_count = 0;
    srm_top dut_u (
        .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pos_in(pos_in),
        .pos_valid(pos_valid), .stop_req(stop_req), .alarm_reset(alarm_reset), .front_key(front_key),
        .stop_ramp_monitor_ok(ok), .standstill_monitor_en(sten), .irq(irq));
    srm_enc_model enc_u (
        .core_clk(core_clk), .nrst(nrst), .v_set(v_set), .v_load(v_load), .v_dec(v_dec),
        .pos_in(pos_in), .pos_valid(pos_valid));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] q);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        @(posedge core_clk);
        // no cycle count assumed; only the watchdog ends a stuck wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    // configure, run at speed 20, then raise the stop with a given drive deceleration
    task automatic arm(input logic [31:0] ctrl, input logic [31:0] mg, input logic [31:0] jk,
                       input logic [31:0] dc);
        wr(OFS_CTRL, ctrl);
        wr(OFS_LAT, 32'h2);
        wr(OFS_MARGIN, mg);
        wr(OFS_ACCEL, 32'h4);
        wr(OFS_JERK, jk);
        v_set <= 32'h14;
        v_dec <= 32'h0;
        v_load <= 1'b1;
        @(posedge core_clk);
        v_load <= 1'b0;
        repeat (40) @(posedge core_clk);
        stop_req <= 1'b1;
        v_dec <= dc;
        repeat (120) @(posedge core_clk);
    endtask : arm
    task automatic halt();
        stop_req <= 1'b0;
        v_set <= 32'h0;
        v_load <= 1'b1;
        @(posedge core_clk);
        v_load <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : halt
    task automatic pulse(input logic key);
        if (key) front_key <= 1'b1;
        else alarm_reset <= 1'b1;
        @(posedge core_clk);
        front_key <= 1'b0;
        alarm_reset <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pulse
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 4'(i), 32'h0, rd);
            check(rd, rst_tab[i]);
        end
        wr(4'hF, 32'hFFFF_FFFF);
        bus(1'b0, 4'hF, 32'h0, rd);
        check(rd, RD_UNMAPPED);
        check(32'(ok), 32'h1);
        wr(OFS_MASK, 32'h7);
        arm(32'h1, 32'h2, 32'h1, 32'h4);
        check(32'(ok), 32'h1);
        check(32'(sten), 32'h1);
        bus(1'b0, OFS_STAT, 32'h0, rd);
        check(rd, 32'h2F);
        halt();
        check(32'(sten), 32'h0);
        wr(OFS_IRQ, 32'h7);
        check(32'(irq), 32'h0);
        arm(32'h0, 32'h2, 32'h1, 32'h4);
        check(32'(ok), 32'h0);
        bus(1'b0, OFS_STAT, 32'h0, rd);
        check(rd, 32'h0B);
        bus(1'b0, OFS_IRQ, 32'h0, rd);
        check(rd, 32'h6);
        halt();
        wr(OFS_IRQ, 32'h7);
        arm(32'h0, 32'h2, 32'h1, 32'h0);
        check(32'(ok), 32'h0);
        check(32'(irq), 32'h1);
        halt();
        check(32'(ok), 32'h0);
        wr(OFS_MASK, 32'h0);
        check(32'(irq), 32'h0);
        wr(OFS_MASK, 32'h7);
        wr(OFS_IRQ, 32'h7);
        check(32'(irq), 32'h0);
        pulse(1'b0);
        check(32'(ok), 32'h1);
        arm(32'h1, 32'h64, 32'h1, 32'h0);
        check(32'(ok), 32'h1);
        halt();
        arm(32'h3, 32'h2, 32'h0, 32'h0);
        bus(1'b0, OFS_STAT, 32'h0, rd);
        check(rd, 32'h22);
        bus(1'b0, OFS_SPEED, 32'h0, rd);
        check(rd, 32'h14);
        bus(1'b0, OFS_LIMIT, 32'h0, rd);
        check(rd, 32'h16);
        halt();
        arm(32'h3, 32'h2, 32'h1, 32'h0);
        check(32'(ok), 32'h0);
        halt();
        pulse(1'b1);
        check(32'(ok), 32'h1);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
